//--- mss_ctrl_model.sv
// External controller model driving select terminals and run command
`timescale 1ns/1ps

module mss_ctrl_model
#(
   parameter int SETTLE_CYC = 16
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [2:0] cmd_req,
   input wire logic run_req,
   output logic [8:0] term_in,
   output logic [1:0] run_cmd_in
);
   logic [2:0] cmd_q;
   logic run_q;
   int stable_q;

   always_ff @(posedge mclk)
   begin
      cmd_q <= cmd_req;
      stable_q <= (srst || cmd_req != cmd_q) ? 0 : stable_q + 1;
      run_q <= !srst && run_req && (run_q || stable_q >= SETTLE_CYC);
   end

   // Spare terminals idle low; run on the second command only
   assign term_in = {6'h00, cmd_q};
   assign run_cmd_in = {run_q, 1'b0};
endmodule

//--- mss_params.svh
// Offsets, field positions, reset values and timing counts of the motor set selector
`ifndef MSS_PARAMS_SVH
`define MSS_PARAMS_SVH

// Register byte addresses
`define MSS_ADDR_MODE      8'h00
`define MSS_ADDR_STATUS    8'h04
`define MSS_ADDR_FUNC_EN   8'h08
`define MSS_ADDR_SW_MASK   8'h0C
`define MSS_ADDR_IN_BASE   8'h20
`define MSS_ADDR_OUT_BASE  8'h48
`define MSS_ADDR_TI_BASE   8'h70
`define MSS_ADDR_PAR_BASE  8'h80

// Status field positions
`define MSS_ST_SET_LSB     0
`define MSS_ST_PEND_BIT    2
`define MSS_ST_RUN_BIT     3
`define MSS_ST_CMD_LSB     4

// Terminal function codes
`define MSS_FC_SEL_TWO     8'h0C
`define MSS_FC_SEL_THREE   8'h24
`define MSS_FC_SEL_FOUR    8'h25
`define MSS_FC_OUT_ONE     8'h30
`define MSS_FC_OUT_TWO     8'h31
`define MSS_FC_OUT_THREE   8'h32
`define MSS_FC_OUT_FOUR    8'h33

// Mode values
`define MSS_MODE_MOTOR     1'b0
`define MSS_MODE_PARAM     1'b1

// Reset values
`define MSS_RST_MODE       3'h0
`define MSS_RST_FUNC_EN    8'h00
`define MSS_RST_SW_MASK    8'h00
`define MSS_RST_CODE       8'h00
`define MSS_RST_TI         14'h0064
`define MSS_RST_PAR        16'h0000

// Integral time limits in 1 ms units
`define MSS_TI_MIN         14'h0001
`define MSS_TI_MAX         14'h270F
`define MSS_TI_DISABLE     14'h03E7

// Select settle time owed by the controller
`define MSS_SETTLE_US      2000
`define MSS_CLK_MHZ        125
`define MSS_SETTLE_CYC     (`MSS_SETTLE_US * `MSS_CLK_MHZ)

`endif

//--- mss_pkg.sv
// Types shared by the motor set selector
package mss_pkg;

   typedef enum logic [1:0]
   {
      MSS_SET_ONE,
      MSS_SET_TWO,
      MSS_SET_THREE,
      MSS_SET_FOUR
   } mss_set_t;

endpackage

//--- mss_selector.sv
// Motor parameter set selector: terminal decode, change gating, parameter swap
//
// Behaviour
// - Set-two command wins over three and four
// - Set-three command wins over four
// - Four alone selects four; none selects one
// - Exactly one selected indication is asserted
// - Input terminals take select codes 12/36/37
// - Output terminals take indication codes 48-51
// - Motor switch swaps the whole parameter group
// - Mode 0 changes only while stopped
// - Mode 1 changes even while running when the other end is set one or also mode 1
// - Parameter switch swaps only marked parameters
// - Set-one-only functions ignored for sets 2-4
// - Integral time 1-9999 ms, 999 disables
// - Sets two to four own a mode bit
`timescale 1ns/1ps
`include "mss_params.svh"

module mss_selector
   import mss_pkg::*;
#(
   parameter int N_IN = 9,
   parameter int N_OUT = 8,
   parameter int N_RUN = 2,
   parameter int N_PAR = 8,
   parameter int PAR_W = 16,
   parameter int SETTLE_CYC = `MSS_SETTLE_CYC
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [N_IN-1:0] term_in,
   input wire logic [N_RUN-1:0] run_cmd_in,
   output logic [N_OUT-1:0] term_out,
   output logic set_one_selected_out,
   output logic set_two_selected_out,
   output logic set_three_selected_out,
   output logic set_four_selected_out,
   output logic [N_PAR*PAR_W-1:0] active_par_out,
   output logic [7:0] func_en_out,
   output logic [13:0] speed_regulator_ti_out,
   output logic speed_regulator_i_en_out,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [N_IN-1:0] term_meta_q;
   logic [N_IN-1:0] term_sync_q;
   logic [N_RUN-1:0] run_meta_q;
   logic [N_RUN-1:0] run_sync_q;

   always_ff @(posedge mclk)
   begin
      term_meta_q <= term_in;
      term_sync_q <= term_meta_q;
      run_meta_q <= run_cmd_in;
      run_sync_q <= run_meta_q;
   end

   // ****************************************
   // Software registers
   // ****************************************
   logic [2:0] mode_q;
   logic [7:0] func_en_q;
   logic [N_PAR-1:0] sw_mask_q;
   logic [7:0] in_code_q [N_IN];
   logic [7:0] out_code_q [N_OUT];
   logic [13:0] ti_q [4];
   logic [PAR_W-1:0] par_q [4][N_PAR];
   mss_set_t set_q;
   logic pending;
   logic running;
   logic [2:0] cmd;

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         mode_q <= `MSS_RST_MODE;
         func_en_q <= `MSS_RST_FUNC_EN;
         sw_mask_q <= N_PAR'(`MSS_RST_SW_MASK);
      end
      else if (reg_wr)
      begin
         if (reg_addr == `MSS_ADDR_MODE)
         begin
            mode_q <= reg_wdata[2:0];
         end
         if (reg_addr == `MSS_ADDR_FUNC_EN)
         begin
            func_en_q <= reg_wdata[7:0];
         end
         if (reg_addr == `MSS_ADDR_SW_MASK)
         begin
            sw_mask_q <= reg_wdata[N_PAR-1:0];
         end
      end
   end

   genvar gi;
   genvar gs;

   generate
      for (gi = 0; gi < N_IN; gi++)
      begin : g_in_code
         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               in_code_q[gi] <= `MSS_RST_CODE;
            end
            else if (reg_wr && reg_addr == 8'(`MSS_ADDR_IN_BASE + 4 * gi))
            begin
               in_code_q[gi] <= reg_wdata[7:0];
            end
         end
      end
   endgenerate

   generate
      for (gi = 0; gi < N_OUT; gi++)
      begin : g_out_code
         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               out_code_q[gi] <= `MSS_RST_CODE;
            end
            else if (reg_wr && reg_addr == 8'(`MSS_ADDR_OUT_BASE + 4 * gi))
            begin
               out_code_q[gi] <= reg_wdata[7:0];
            end
         end
      end
   endgenerate

   // Integral time per set, out-of-range writes dropped to keep the old value
   generate
      for (gs = 0; gs < 4; gs++)
      begin : g_ti
         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               ti_q[gs] <= `MSS_RST_TI;
            end
            else if (reg_wr && reg_addr == 8'(`MSS_ADDR_TI_BASE + 4 * gs)
                     && reg_wdata[31:14] == 18'h0_0000
                     && reg_wdata[13:0] >= `MSS_TI_MIN && reg_wdata[13:0] <= `MSS_TI_MAX)
            begin
               ti_q[gs] <= reg_wdata[13:0];
            end
         end
      end
   endgenerate

   // Per-set parameter storage
   generate
      for (gs = 0; gs < 4; gs++)
      begin : g_par_set
         for (gi = 0; gi < N_PAR; gi++)
         begin : g_par
            always_ff @(posedge mclk)
            begin
               if (srst)
               begin
                  par_q[gs][gi] <= PAR_W'(`MSS_RST_PAR);
               end
               else if (reg_wr && reg_addr == 8'(`MSS_ADDR_PAR_BASE + 4 * (gs * N_PAR + gi)))
               begin
                  par_q[gs][gi] <= reg_wdata[PAR_W-1:0];
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Command decode
   // ****************************************
   logic [N_IN-1:0] hit_two;
   logic [N_IN-1:0] hit_three;
   logic [N_IN-1:0] hit_four;
   logic select_set_two_cmd;
   logic select_set_three_cmd;
   logic select_set_four_cmd;
   mss_set_t req_set;

   generate
      for (gi = 0; gi < N_IN; gi++)
      begin : g_hit
         assign hit_two[gi] = term_sync_q[gi] && in_code_q[gi] == `MSS_FC_SEL_TWO;
         assign hit_three[gi] = term_sync_q[gi] && in_code_q[gi] == `MSS_FC_SEL_THREE;
         assign hit_four[gi] = term_sync_q[gi] && in_code_q[gi] == `MSS_FC_SEL_FOUR;
      end
   endgenerate

   assign select_set_two_cmd = |hit_two;
   assign select_set_three_cmd = |hit_three;
   assign select_set_four_cmd = |hit_four;
   assign cmd = {select_set_four_cmd, select_set_three_cmd, select_set_two_cmd};
   assign running = |run_sync_q;

   always_comb
   begin
      if (select_set_two_cmd)
      begin
         req_set = MSS_SET_TWO;
      end
      else if (select_set_three_cmd)
      begin
         req_set = MSS_SET_THREE;
      end
      else if (select_set_four_cmd)
      begin
         req_set = MSS_SET_FOUR;
      end
      else
      begin
         req_set = MSS_SET_ONE;
      end
   end

   // ****************************************
   // Change gating
   // ****************************************
   // Set one has no mode bit and never blocks a running change by itself
   function automatic logic is_param_mode(input mss_set_t s, input logic [2:0] m);
      logic r;
      r = `MSS_MODE_PARAM;
      case (s)
         MSS_SET_TWO: r = m[0];
         MSS_SET_THREE: r = m[1];
         MSS_SET_FOUR: r = m[2];
         default: r = `MSS_MODE_PARAM;
      endcase
      return r;
   endfunction

   logic run_ok;
   logic change_ok;

   // both ends in parameter mode may change while running
   assign run_ok = is_param_mode(req_set, mode_q) && is_param_mode(set_q, mode_q);
   assign change_ok = !running || run_ok;
   // held request stays visible as pending
   assign pending = req_set != set_q;

   // request re-evaluated each cycle, applied once stopped or while both ends are in parameter mode
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         set_q <= MSS_SET_ONE;
      end
      else if (pending && change_ok)
      begin
         set_q <= req_set;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic [N_PAR*PAR_W-1:0] active_par_d;
   logic [3:0] sel_onehot;
   logic set_param_mode;

   assign set_param_mode = set_q != MSS_SET_ONE && is_param_mode(set_q, mode_q);

   generate
      for (gi = 0; gi < N_PAR; gi++)
      begin : g_active
         // in parameter mode, unmarked parameters stay at set one
         assign active_par_d[gi*PAR_W +: PAR_W] = (set_param_mode && !sw_mask_q[gi])
            ? par_q[0][gi] : par_q[set_q][gi];
      end
   endgenerate

   // one-hot indication from the selected set
   always_comb
   begin
      sel_onehot = 4'h0;
      sel_onehot[set_q] = 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         active_par_out <= '0;
         set_one_selected_out <= 1'b1;
         set_two_selected_out <= 1'b0;
         set_three_selected_out <= 1'b0;
         set_four_selected_out <= 1'b0;
         func_en_out <= 8'h00;
         speed_regulator_ti_out <= `MSS_RST_TI;
         speed_regulator_i_en_out <= 1'b1;
      end
      else
      begin
         active_par_out <= active_par_d;
         set_one_selected_out <= sel_onehot[0];
         set_two_selected_out <= sel_onehot[1];
         set_three_selected_out <= sel_onehot[2];
         set_four_selected_out <= sel_onehot[3];
         func_en_out <= (set_q == MSS_SET_ONE) ? func_en_q : 8'h00;
         speed_regulator_ti_out <= ti_q[set_q];
         speed_regulator_i_en_out <= ti_q[set_q] != `MSS_TI_DISABLE;
      end
   end

   // output terminal follows its indication code
   generate
      for (gi = 0; gi < N_OUT; gi++)
      begin : g_term_out
         always_ff @(posedge mclk)
         begin
            if (srst)
            begin
               term_out[gi] <= 1'b0;
            end
            else
            begin
               case (out_code_q[gi])
                  `MSS_FC_OUT_ONE: term_out[gi] <= sel_onehot[0];
                  `MSS_FC_OUT_TWO: term_out[gi] <= sel_onehot[1];
                  `MSS_FC_OUT_THREE: term_out[gi] <= sel_onehot[2];
                  `MSS_FC_OUT_FOUR: term_out[gi] <= sel_onehot[3];
                  default: term_out[gi] <= 1'b0;
               endcase
            end
         end
      end
   endgenerate

   // ****************************************
   // Read port
   // ****************************************
   logic [31:0] rd_d;

   always_comb
   begin
      rd_d = 32'h0000_0000;
      if (reg_addr == `MSS_ADDR_MODE)
      begin
         rd_d[2:0] = mode_q;
      end
      if (reg_addr == `MSS_ADDR_STATUS)
      begin
         rd_d[`MSS_ST_SET_LSB +: 2] = set_q;
         rd_d[`MSS_ST_PEND_BIT] = pending;
         rd_d[`MSS_ST_RUN_BIT] = running;
         rd_d[`MSS_ST_CMD_LSB +: 3] = cmd;
      end
      if (reg_addr == `MSS_ADDR_FUNC_EN)
      begin
         rd_d[7:0] = func_en_q;
      end
      if (reg_addr == `MSS_ADDR_SW_MASK)
      begin
         rd_d[N_PAR-1:0] = sw_mask_q;
      end
      for (int i = 0; i < N_IN; i++)
      begin
         if (reg_addr == 8'(`MSS_ADDR_IN_BASE + 4 * i))
         begin
            rd_d[7:0] = in_code_q[i];
         end
      end
      for (int i = 0; i < N_OUT; i++)
      begin
         if (reg_addr == 8'(`MSS_ADDR_OUT_BASE + 4 * i))
         begin
            rd_d[7:0] = out_code_q[i];
         end
      end
      for (int s = 0; s < 4; s++)
      begin
         if (reg_addr == 8'(`MSS_ADDR_TI_BASE + 4 * s))
         begin
            rd_d[13:0] = ti_q[s];
         end
         for (int i = 0; i < N_PAR; i++)
         begin
            if (reg_addr == 8'(`MSS_ADDR_PAR_BASE + 4 * (s * N_PAR + i)))
            begin
               rd_d[PAR_W-1:0] = par_q[s][i];
            end
         end
      end
   end

   // Unmapped or idle reads return zero
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         reg_rdata <= 32'h0000_0000;
      end
      else
      begin
         reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
      end
   end

endmodule

//--- mss_selector_asserts.sv
// Port-level concurrent checks for the motor set selector
`timescale 1ns/1ps
`include "mss_params.svh"

module mss_selector_asserts
#(
   parameter int N_IN = 9,
   parameter int N_RUN = 2
)
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic [N_IN-1:0] term_in,
   input wire logic [N_RUN-1:0] run_cmd_in,
   input wire logic set_one_selected_out,
   input wire logic set_two_selected_out,
   input wire logic set_three_selected_out,
   input wire logic set_four_selected_out,
   input wire logic [7:0] func_en_out,
   input wire logic [13:0] speed_regulator_ti_out,
   input wire logic speed_regulator_i_en_out,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   logic [2:0] mode_q;
   logic [3:0] sel;
   logic run_act;
   assign sel = {set_four_selected_out, set_three_selected_out, set_two_selected_out, set_one_selected_out};
   assign run_act = |run_cmd_in;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   // Shadow of mode bits, tells when a change must wait
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         mode_q <= 3'h0;
      end
      else if (reg_wr && reg_addr == `MSS_ADDR_MODE)
      begin
         mode_q <= reg_wdata[2:0];
      end
   end

   // ****************************************
   // Properties
   // ****************************************
   // one-hot select
   property p_one_hot;
      $onehot(sel);
   endproperty
   a_one_hot: assert property (p_one_hot) else $error("selected outputs not one-hot");
   property p_idle_one;
      (term_in == '0 && !run_act) [*6] |=> set_one_selected_out;
   endproperty
   a_idle_one: assert property (p_idle_one) else $error("set one not selected when idle");
   property p_run_hold;
      (run_act && mode_q == 3'h0) [*6] |=> $stable(sel);
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("set changed while running");
   property p_func_one;
      !set_one_selected_out |-> func_en_out == 8'h00;
   endproperty
   a_func_one: assert property (p_func_one) else $error("function enable outside set one");
   property p_i_en;
      speed_regulator_i_en_out == (speed_regulator_ti_out != `MSS_TI_DISABLE);
   endproperty
   a_i_en: assert property (p_i_en) else $error("integral enable wrong");
   property p_ti_range;
      speed_regulator_ti_out >= `MSS_TI_MIN && speed_regulator_ti_out <= `MSS_TI_MAX;
   endproperty
   a_ti_range: assert property (p_ti_range) else $error("integral time out of range");
   property p_mode_rd;
      reg_rd && reg_addr == `MSS_ADDR_MODE |=> reg_rdata == {29'h0000_0000, mode_q};
   endproperty
   a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
   // Read data only after a read
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

   c_four: cover property (set_four_selected_out);
   c_hold: cover property ((run_act && mode_q == 3'h0) [*6]);
   c_run_swap: cover property (run_act && $rose(set_two_selected_out));
   c_p_only: cover property (!speed_regulator_i_en_out);
endmodule

bind mss_selector mss_selector_asserts #(.N_IN(N_IN), .N_RUN(N_RUN)) mss_selector_asserts_inst (
   .mclk(mclk),
   .srst(srst),
   .term_in(term_in),
   .run_cmd_in(run_cmd_in),
   .set_one_selected_out(set_one_selected_out),
   .set_two_selected_out(set_two_selected_out),
   .set_three_selected_out(set_three_selected_out),
   .set_four_selected_out(set_four_selected_out),
   .func_en_out(func_en_out),
   .speed_regulator_ti_out(speed_regulator_ti_out),
   .speed_regulator_i_en_out(speed_regulator_i_en_out),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata)
);

//--- tb_mss_selector.sv
// Self-checking bench for the motor set selector
`timescale 1ns/1ps
`include "mss_params.svh"

module tb_mss_selector;
   logic mclk;
   logic srst;
   logic reg_wr;
   logic reg_rd;
   logic run_req;
   logic [2:0] cmd_req;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic [8:0] term_in;
   logic [1:0] run_cmd_in;
   logic [7:0] term_out;
   logic [7:0] func_en_out;
   logic [3:0] sel;
   logic [127:0] active_par_out;
   logic [13:0] ti_out;
   logic i_en;
   int err_total;
   int n_checks;
   int s;

   mss_ctrl_model #(.SETTLE_CYC(16)) mss_ctrl_model_inst (.mclk(mclk), .srst(srst), .cmd_req(cmd_req),
      .run_req(run_req), .term_in(term_in), .run_cmd_in(run_cmd_in));
   mss_selector #(.SETTLE_CYC(16)) mss_selector_inst (.mclk(mclk), .srst(srst), .term_in(term_in),
      .run_cmd_in(run_cmd_in), .term_out(term_out), .set_one_selected_out(sel[0]),
      .set_two_selected_out(sel[1]), .set_three_selected_out(sel[2]), .set_four_selected_out(sel[3]),
      .active_par_out(active_par_out), .func_en_out(func_en_out), .speed_regulator_ti_out(ti_out),
      .speed_regulator_i_en_out(i_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      // Read data stand only until the next rising edge
      @(negedge mclk);
      chk(reg_rdata, exp);
      @(posedge mclk);
   endtask

   // Outputs of one selected set; waits past sync and output stages
   task automatic chk_set(input int s, input logic [31:0] par, input logic [31:0] fe);
      logic [31:0] ti;
      ti = (s == 2) ? 32'h0000_03E7 : (s == 3) ? 32'h0000_270F : 32'h0000_0064;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      chk({28'h000_0000, sel}, 32'h0000_0001 << (s - 1));
      chk({28'h000_0000, term_out[3:0]}, 32'h0000_0001 << (s - 1));
      chk({18'h0_0000, ti_out}, ti);
      chk({31'h0000_0000, i_en}, {31'h0000_0000, ti != 32'h0000_03E7});
      chk({24'h00_0000, func_en_out}, fe);
      chk(active_par_out[31:0], par);
      @(posedge mclk);
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial
   begin
      repeat (5000) @(posedge mclk);
      err_total++;
      conclude();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      err_total = 0;
      n_checks = 0;
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      cmd_req = 3'h0;
      run_req = 1'b0;
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      rchk(`MSS_ADDR_MODE, 32'h0000_0000);
      wr(8'h20, 32'h0000_000C);
      wr(8'h24, 32'h0000_0024);
      wr(8'h28, 32'h0000_0025);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h48 + 8'(4 * i), 32'h0000_0030 + 32'(i));
      end
      // Indications need their codes before the default set can show
      chk_set(1, 32'h0000_0000, 32'h0000_0000);
      wr(8'h80, 32'h0000_1111);
      wr(8'h84, 32'h0000_1B1B);
      wr(8'hA0, 32'h0000_2222);
      wr(8'hA4, 32'h0000_2B2B);
      wr(8'h74, 32'h0000_03E7);
      wr(8'h78, 32'h0000_270F);
      wr(8'h7C, 32'h0000_2710);
      rchk(8'h7C, 32'h0000_0064);
      wr(`MSS_ADDR_FUNC_EN, 32'h0000_00FF);
      // Every command combination, stopped
      for (int c = 0; c < 8; c++)
      begin
         cmd_req <= 3'(c);
         s = c[0] ? 2 : c[1] ? 3 : c[2] ? 4 : 1;
         chk_set(s, s == 1 ? 32'h1B1B_1111 : s == 2 ? 32'h2B2B_2222 : 32'h0000_0000,
            s == 1 ? 32'h0000_00FF : 32'h0000_0000);
      end
      cmd_req <= 3'h0;
      repeat (8) @(posedge mclk);
      run_req <= 1'b1;
      repeat (30) @(posedge mclk);
      cmd_req <= 3'h1;
      chk_set(1, 32'h1B1B_1111, 32'h0000_00FF);
      rchk(`MSS_ADDR_STATUS, 32'h0000_001C);
      run_req <= 1'b0;
      chk_set(2, 32'h2B2B_2222, 32'h0000_0000);
      wr(`MSS_ADDR_MODE, 32'h0000_0007);
      wr(`MSS_ADDR_SW_MASK, 32'h0000_0002);
      rchk(`MSS_ADDR_MODE, 32'h0000_0007);
      cmd_req <= 3'h0;
      repeat (8) @(posedge mclk);
      run_req <= 1'b1;
      repeat (30) @(posedge mclk);
      cmd_req <= 3'h1;
      chk_set(2, 32'h2B2B_1111, 32'h0000_0000);
      cmd_req <= 3'h4;
      chk_set(4, 32'h0000_1111, 32'h0000_0000);
      run_req <= 1'b0;
      wr(8'h10, 32'hFFFF_FFFF);
      rchk(8'h10, 32'h0000_0000);
      conclude();
   end
endmodule
